// ===== verilog/tcc_pkg.sv
/*
 * Constants, field layouts and carrier types of the timer
 * clock, clear and I/O control block.
 * Assumes a 32-bit AHB-Lite register bus, word access only.
 */
package tcc_pkg;

    // ----------------------------------------------------------
    // Sizes
    // ----------------------------------------------------------
    localparam int NCH = 2;
    localparam int NGR = 4;
    localparam int CW  = 16;

    // ----------------------------------------------------------
    // Carrier of the counter control register
    // ----------------------------------------------------------
    typedef struct packed {
        logic [2:0] clr;
        logic [1:0] edge_sel;
        logic [2:0] psc;
    } tcc_tcr_t;

    // Clear select codes
    localparam logic [2:0] CLR_A       = 3'h1;
    localparam logic [2:0] CLR_B       = 3'h2;
    localparam logic [2:0] CLR_C       = 3'h5;
    localparam logic [2:0] CLR_D       = 3'h6;
    localparam logic [1:0] CLR_SYNC_LO = 2'h3;

    // External edge codes
    localparam logic [1:0] EDGE_RISE = 2'h0;
    localparam logic [1:0] EDGE_FALL = 2'h1;
    localparam int         BOTH_BIT  = 1;

    // Prescaler codes
    localparam logic [2:0] PSC_DIV1 = 3'h0;
    localparam logic [2:0] PSC_DIV2 = 3'h1;
    localparam logic [2:0] PSC_DIV4 = 3'h2;
    localparam int         EXT_BIT  = 2;

    // I/O field codes and layout
    localparam int         ROLE_BIT = 2;
    localparam logic [2:0] IO_NONE  = 3'h0;
    localparam logic [2:0] IO_LOW   = 3'h1;
    localparam logic [2:0] IO_HIGH  = 3'h2;
    localparam logic [2:0] IC_RISE  = 3'h4;
    localparam logic [2:0] IC_FALL  = 3'h5;
    localparam int         IO_LO    = 0;
    localparam int         IO_HI    = 4;
    localparam logic [7:0] IO_RSV   = 8'h88;

    // ----------------------------------------------------------
    // Register map, byte addresses
    // ----------------------------------------------------------
    localparam logic [5:0] OFS_TCR  = 6'h00;
    localparam logic [5:0] OFS_IOAB = 6'h04;
    localparam logic [5:0] OFS_IOCD = 6'h08;
    localparam logic [5:0] OFS_CNT  = 6'h0C;
    localparam logic [5:0] OFS_GR   = 6'h10;
    localparam logic [7:0] OFS_MODE = 8'h80;
    localparam int         CH_BIT   = 6;
    localparam int         GLB_BIT  = 7;
    localparam int         SYNC_BIT = 0;
    localparam int         PWM_LSB  = 4;
    localparam logic [1:0] PWM_OFF  = 2'h0;
    localparam logic [1:0] PWM_COMP = 2'h3;

    // Reset values and the up/down count limit
    localparam logic [CW-1:0] GR_RST  = 16'hFFFF;
    localparam logic [CW-1:0] CNT_MAX = 16'hFFFF;
    localparam logic [7:0]    TCR_RST = 8'h00;

endpackage

// ===== verilog/tcc_timer_ctrl.sv
/*
 * Two-channel 16-bit timer: count clock choice, counter clear
 * choice, compare/capture role and pin action of registers A-D.
 * Assumes an AHB-Lite master on CLK and asynchronous pins.
 */
// Notes on behaviour
// - Clear codes 000 and 100 never clear
// - Code 001 clears on A, 010 on B
// - Code 101 clears on C, 110 on D
// - Codes x11 follow other channel's clear
// - Clear event: match or capture per role
// - External edge: rise, fall or both
// - Internal rate full, half, quarter, eighth
// - Prescaler 1xx counts channel 0 pin A
// - Each channel has its own control register
// - PWM modes ignore the I/O fields
// - Compare: none, drive 0, 1 or toggle
// - Capture on rise, fall or both edges
// - Top field bit picks capture role
// - First register A/B, second C/D
// - Two I/O control registers per channel
// - Bits 7 and 3 read one, ignore writes
// - Clear loads the counter with zero
// - Count up only, except complementary PWM
module tcc_timer_ctrl
    import tcc_pkg::*;
(
    input  wire logic        CLK,       // System clock
    input  wire logic        RESET,     // Async reset
    input  wire logic        HSEL,      // Slave select
    input  wire logic [7:0]  HADDR,     // Byte address
    input  wire logic [1:0]  HTRANS,    // Transfer type
    input  wire logic        HWRITE,    // Write
    input  wire logic [2:0]  HSIZE,     // Word only
    input  wire logic [31:0] HWDATA,    // Write data
    input  wire logic        HREADY,    // Bus ready
    output logic      [31:0] HRDATA,    // Read data
    output logic             HREADYOUT, // Slave ready
    output logic             HRESP,     // Always OKAY
    input  wire logic [7:0]  PIN_IN,    // Pins, ch*4+reg
    output logic      [7:0]  PIN_OUT,   // Pin levels
    output logic      [7:0]  PIN_OE     // Pin drives
);

    // ----------------------------------------------------------
    // State
    // ----------------------------------------------------------
    tcc_tcr_t      tcr_reg [NCH];
    tcc_tcr_t      tcr_next[NCH];
    logic [7:0]    io_reg  [NCH][2];
    logic [7:0]    io_next [NCH][2];
    logic [CW-1:0] cnt_reg [NCH];
    logic [CW-1:0] cnt_next[NCH];
    logic [CW-1:0] gr_reg  [NCH][NGR];
    logic [CW-1:0] gr_next [NCH][NGR];
    logic [NCH-1:0] dir_reg, dir_next;
    logic [7:0]    mode_reg, mode_next;
    logic [2:0]    pre_reg, pre_next;
    logic [7:0]    pout_reg, pout_next;
    logic [7:0]    poe_reg, poe_next;
    logic [7:0]    s1_reg, s2_reg, s3_reg;
    logic          wp_reg, wp_next;
    logic          rp_reg, rp_next;
    logic [7:0]    ad_reg, ad_next;
    logic [31:0]   rd_reg, rd_next;
    logic          rdy_reg, rdy_next;

    // Events, combinational
    logic [NCH-1:0] tick, own_clr, clr_evt;
    logic [NGR-1:0] ev   [NCH];
    logic [NGR-1:0] match[NCH];
    logic [NGR-1:0] capt [NCH];
    logic [7:0]     rise, fall;

    // ----------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------
    // Third stage is the previous sample for edge detection
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            s1_reg <= 8'h00;
            s2_reg <= 8'h00;
            s3_reg <= 8'h00;
        end else begin
            s1_reg <= PIN_IN;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end
    assign rise = s2_reg & ~s3_reg;
    assign fall = ~s2_reg & s3_reg;

    // ----------------------------------------------------------
    // AHB-Lite slave
    // ----------------------------------------------------------
    // Read data is looked up one cycle after the address phase,
    // so reads take one wait state and always see prior writes.
    function automatic logic [31:0] rd_mux(input logic [7:0] a);
        logic       c;
        logic [5:0] o;
        c = a[CH_BIT];
        o = a[5:0];
        rd_mux = 32'h0000_0000;
        if (a == OFS_MODE) begin
            rd_mux[7:0] = mode_reg;
        end else if (!a[GLB_BIT]) begin
            unique case (o)
                OFS_TCR:  rd_mux[7:0] = tcr_reg[c];
                OFS_IOAB: rd_mux[7:0] = io_reg[c][0];
                OFS_IOCD: rd_mux[7:0] = io_reg[c][1];
                OFS_CNT:  rd_mux[CW-1:0] = cnt_reg[c];
                default: begin
                    if (o[5:4] == OFS_GR[5:4] && o[1:0] == 2'h0) begin
                        rd_mux[CW-1:0] = gr_reg[c][o[3:2]];
                    end
                end
            endcase
        end
    endfunction

    // Address phase capture and read wait state
    always_comb begin
        logic ap;
        ap = HSEL & HTRANS[1] & HREADY;
        wp_next  = ap & HWRITE;
        rp_next  = ap & ~HWRITE;
        ad_next  = ap ? HADDR : ad_reg;
        rdy_next = ~(ap & ~HWRITE);
        rd_next  = rp_reg ? rd_mux(ad_reg) : rd_reg;
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            wp_reg  <= 1'b0;
            rp_reg  <= 1'b0;
            ad_reg  <= 8'h00;
            rdy_reg <= 1'b1;
            rd_reg  <= 32'h0000_0000;
        end else begin
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            ad_reg  <= ad_next;
            rdy_reg <= rdy_next;
            rd_reg  <= rd_next;
        end
    end

    assign HRDATA    = rd_reg;
    assign HREADYOUT = rdy_reg;
    assign HRESP     = 1'b0;

    // ----------------------------------------------------------
    // Event decode per channel
    // ----------------------------------------------------------
    always_comb begin
        tick    = '0;
        own_clr = '0;
        clr_evt = '0;
        for (int c = 0; c < NCH; c++) begin
            logic [2:0] io;
            logic       pwm, ext;
            io  = 3'h0;
            pwm = mode_reg[PWM_LSB+2*c +: 2] != PWM_OFF;
            ext = tcr_reg[c].edge_sel[BOTH_BIT] ? rise[0] | fall[0]
                : tcr_reg[c].edge_sel == EDGE_FALL ? fall[0]
                : rise[0];
            if (tcr_reg[c].psc[EXT_BIT]) begin
                tick[c] = ext;
            end else begin
                unique case (tcr_reg[c].psc)
                    PSC_DIV1: tick[c] = 1'b1;
                    PSC_DIV2: tick[c] = pre_reg[0];
                    PSC_DIV4: tick[c] = &pre_reg[1:0];
                    default:  tick[c] = &pre_reg;
                endcase
            end
            for (int g = 0; g < NGR; g++) begin
                // Field g: A/B in first register, C/D in second
                io = io_reg[c][g/2][(g%2)*IO_HI +: 3];
                match[c][g] = tick[c] && cnt_reg[c] == gr_reg[c][g]
                            && (pwm || !io[ROLE_BIT]);
                capt[c][g] = !pwm && io[ROLE_BIT]
                           && (io[1] ? rise[4*c+g] | fall[4*c+g]
                               : io == IC_FALL ? fall[4*c+g]
                               : rise[4*c+g]);
                ev[c][g] = match[c][g] | capt[c][g];
            end
            unique case (tcr_reg[c].clr)
                CLR_A:   own_clr[c] = ev[c][0];
                CLR_B:   own_clr[c] = ev[c][1];
                CLR_C:   own_clr[c] = ev[c][2];
                CLR_D:   own_clr[c] = ev[c][3];
                default: own_clr[c] = 1'b0;
            endcase
        end
        // Sync clear follows the partner's own source only, so a
        // channel pair both set to sync cannot loop.
        for (int c = 0; c < NCH; c++) begin
            clr_evt[c] = own_clr[c]
                | (tcr_reg[c].clr[1:0] == CLR_SYNC_LO
                   && mode_reg[SYNC_BIT] && own_clr[1-c]);
        end
    end

    // ----------------------------------------------------------
    // Timer next state
    // ----------------------------------------------------------
    // Software writes are applied last and win over hardware.
    always_comb begin
        logic [5:0] o;
        logic       c;
        logic [2:0] io;
        o         = ad_reg[5:0];
        c         = ad_reg[CH_BIT];
        io        = 3'h0;
        pre_next  = pre_reg + 3'h1;
        mode_next = mode_reg;
        dir_next  = dir_reg;
        pout_next = pout_reg;
        poe_next  = poe_reg;
        tcr_next  = tcr_reg;
        io_next   = io_reg;
        cnt_next  = cnt_reg;
        gr_next   = gr_reg;
        for (int k = 0; k < NCH; k++) begin
            logic pwm;
            pwm = mode_reg[PWM_LSB+2*k +: 2] != PWM_OFF;
            if (clr_evt[k]) begin
                cnt_next[k] = '0;
            end else if (tick[k]) begin
                if (mode_reg[PWM_LSB+2*k +: 2] != PWM_COMP) begin
                    cnt_next[k] = cnt_reg[k] + 16'h0001;
                end else if (dir_reg[k]) begin
                    dir_next[k] = cnt_reg[k] != CNT_MAX;
                    cnt_next[k] = dir_next[k] ? cnt_reg[k] + 16'h0001
                                : cnt_reg[k] - 16'h0001;
                end else begin
                    dir_next[k] = cnt_reg[k] == '0;
                    cnt_next[k] = dir_next[k] ? cnt_reg[k] + 16'h0001
                                : cnt_reg[k] - 16'h0001;
                end
            end
            for (int g = 0; g < NGR; g++) begin
                io = io_reg[k][g/2][(g%2)*IO_HI +: 3];
                if (capt[k][g]) begin
                    gr_next[k][g] = cnt_reg[k];
                end
                poe_next[4*k+g] = !pwm && !io[ROLE_BIT]
                                && io != IO_NONE;
                if (match[k][g] && !pwm && !io[ROLE_BIT]) begin
                    unique case (io[1:0])
                        IO_LOW[1:0]:  pout_next[4*k+g] = 1'b0;
                        IO_HIGH[1:0]: pout_next[4*k+g] = 1'b1;
                        IO_NONE[1:0]: pout_next[4*k+g] = pout_reg[4*k+g];
                        default:      pout_next[4*k+g] = ~pout_reg[4*k+g];
                    endcase
                end
            end
        end
        if (wp_reg && ad_reg == OFS_MODE) begin
            mode_next = HWDATA[7:0];
        end else if (wp_reg && !ad_reg[GLB_BIT]) begin
            unique case (o)
                OFS_TCR:  tcr_next[c] = HWDATA[7:0];
                OFS_IOAB: io_next[c][0] = HWDATA[7:0] | IO_RSV;
                OFS_IOCD: io_next[c][1] = HWDATA[7:0] | IO_RSV;
                OFS_CNT:  cnt_next[c] = HWDATA[CW-1:0];
                default: begin
                    if (o[5:4] == OFS_GR[5:4] && o[1:0] == 2'h0) begin
                        gr_next[c][o[3:2]] = HWDATA[CW-1:0];
                    end
                end
            endcase
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            pre_reg  <= 3'h0;
            mode_reg <= 8'h00;
            dir_reg  <= '1;
            pout_reg <= 8'h00;
            poe_reg  <= 8'h00;
            for (int k = 0; k < NCH; k++) begin
                tcr_reg[k]    <= TCR_RST;
                io_reg[k][0]  <= IO_RSV;
                io_reg[k][1]  <= IO_RSV;
                cnt_reg[k]    <= '0;
                for (int g = 0; g < NGR; g++) begin
                    gr_reg[k][g] <= GR_RST;
                end
            end
        end else begin
            pre_reg  <= pre_next;
            mode_reg <= mode_next;
            dir_reg  <= dir_next;
            pout_reg <= pout_next;
            poe_reg  <= poe_next;
            tcr_reg  <= tcr_next;
            io_reg   <= io_next;
            cnt_reg  <= cnt_next;
            gr_reg   <= gr_next;
        end
    end

    assign PIN_OUT = pout_reg;
    assign PIN_OE  = poe_reg;

    // ----------------------------------------------------------
    // Checks on channel 0
    // ----------------------------------------------------------
    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);

    sequence s_div8_tick;
        tick[0] && tcr_reg[0].psc == 3'h3;
    endsequence

    a_clear_none_off: assert property (
        tcr_reg[0].clr[1:0] == 2'h0 |-> !clr_evt[0])
        else $error("clear fired with clearing off");
    a_clear_by_a: assert property (
        tcr_reg[0].clr == CLR_A && ev[0][0] && !wp_reg |=> cnt_reg[0] == '0)
        else $error("A event did not clear counter");
    a_clear_by_d: assert property (
        tcr_reg[0].clr == CLR_D && ev[0][3] && !wp_reg |=> cnt_reg[0] == '0)
        else $error("D event did not clear counter");
    a_sync_clear_pair: assert property (
        tcr_reg[0].clr[1:0] == CLR_SYNC_LO && mode_reg[SYNC_BIT]
        && own_clr[1] |-> clr_evt[0] && clr_evt[1])
        else $error("sync clear not shared");
    a_ext_rise_count: assert property (
        tcr_reg[0].psc[EXT_BIT] && tcr_reg[0].edge_sel == EDGE_RISE
        |-> tick[0] == rise[0])
        else $error("external rise count wrong");
    a_div8_spacing: assert property (
        s_div8_tick |=> !(tick[0] && tcr_reg[0].psc == 3'h3) [*7]
        ##1 (tick[0] || tcr_reg[0].psc != 3'h3))
        else $error("eighth rate spacing wrong");
    a_pwm_no_drive: assert property (
        mode_reg[PWM_LSB +: 2] != PWM_OFF |=> PIN_OE[3:0] == 4'h0)
        else $error("pin driven in PWM mode");
    a_match_drive_high: assert property (
        match[0][0] && io_reg[0][0][2:0] == IO_HIGH
        && mode_reg[PWM_LSB +: 2] == PWM_OFF |=> PIN_OUT[0] && PIN_OE[0])
        else $error("compare did not drive pin high");
    a_capture_value: assert property (
        capt[0][1] && !wp_reg |=> gr_reg[0][1] == $past(cnt_reg[0]))
        else $error("capture value wrong");
    a_reserved_ones: assert property (
        (io_reg[0][0] & IO_RSV) == IO_RSV && (io_reg[0][1] & IO_RSV) == IO_RSV)
        else $error("reserved bits not one");
    a_count_up_only: assert property (
        tick[0] && !clr_evt[0] && !wp_reg
        && mode_reg[PWM_LSB +: 2] != PWM_COMP
        |=> cnt_reg[0] == $past(cnt_reg[0]) + 16'h0001)
        else $error("counter did not step up");

endmodule

// ===== dv/tcc_pin_model.sv
/*
 * Pin-side model: the world outside the eight timer pins.
 * Assumes a pin reads back the timer's own level while the timer drives it.
 */
module tcc_pin_model
    import tcc_pkg::*;
(
    PIN_OUT,   // Timer pin levels
    PIN_OE,    // Timer pin drives
    EXT_LEVEL, // Level the outside source applies
    PIN_IN     // Level seen on each wire
);
    input  wire logic [7:0] PIN_OUT;
    input  wire logic [7:0] PIN_OE;
    input  wire logic [7:0] EXT_LEVEL;
    output logic      [7:0] PIN_IN;

    // ----------------------------------------------------------
    // Wire resolution
    // ----------------------------------------------------------
    // A driving timer wins; pin 0 doubles as the external count clock
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            PIN_IN[i] = PIN_OE[i] ? PIN_OUT[i] : EXT_LEVEL[i];
        end
    end
endmodule

// ===== dv/timer_clock_clear_io_control_tb.sv
/*
 * Self-checking bench of the timer clock, clear and I/O control block.
 * Assumes one AHB-Lite slave with HREADY looped back from HREADYOUT.
 */
module timer_clock_clear_io_control_tb
    import tcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct packed {
        logic        wr;
        logic [7:0]  a;
        logic [31:0] d;
        logic [31:0] e;
    } tcc_row_t;

    // ----------------------------------------------------------
    // Signals
    // ----------------------------------------------------------
    localparam int LIMIT = 20000;
    logic        clk;
    logic        reset;
    logic        hsel;
    logic        hwrite;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
    logic [7:0]  pin_in;
    logic [7:0]  pin_out;
    logic [7:0]  pin_oe;
    logic [7:0]  ext_lvl;
    logic [31:0] v0;
    logic [31:0] v1;
    int          err_count;
    int          total_checks;
    int          cyc;
    int          t0;
    int          clr_code[6] = '{1, 2, 5, 6, 0, 4};
    tcc_row_t    rows[8] = '{
        '{1'b1, 8'h00, 32'h0000_00FF, 32'h0000_00FF},
        '{1'b1, 8'h40, 32'h0000_005A, 32'h0000_005A},
        '{1'b0, 8'h00, 32'h0000_0000, 32'h0000_00FF},
        '{1'b1, 8'h04, 32'h0000_0077, 32'h0000_00FF},
        '{1'b1, 8'h04, 32'h0000_0000, 32'h0000_0088},
        '{1'b1, 8'h48, 32'h0000_0055, 32'h0000_00DD},
        '{1'b1, 8'h20, 32'h0000_00AB, 32'h0000_0000},
        '{1'b1, 8'h14, 32'h0000_BEEF, 32'h0000_BEEF}};

    tcc_timer_ctrl u_tcc_timer_ctrl (
        .CLK(clk), .RESET(reset), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .PIN_IN(pin_in), .PIN_OUT(pin_out), .PIN_OE(pin_oe));

    tcc_pin_model u_tcc_pin_model (
        .PIN_OUT(pin_out), .PIN_OE(pin_oe), .EXT_LEVEL(ext_lvl), .PIN_IN(pin_in));

    // ----------------------------------------------------------
    // Clock, cycle count and hang limit
    // ----------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // A hang counts as a mismatch and ends the run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            err_count++;
            stop_test();
        end
    end

    // ----------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------
    task automatic stop_test();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic check_val(input string n, input logic [31:0] e, input logic [31:0] s);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic check_bit(input string n, input logic e, input logic s);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s expected %b seen %b", n, e, s);
        end
    endtask

    // Address phase held until hready, then data phase until hready
    task automatic bus_cycle(input logic wr, input logic [7:0] a, input logic [31:0] d,
                             output logic [31:0] q);
        @(posedge clk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= a;
        hwrite <= wr;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus_cycle(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] q);
        bus_cycle(1'b0, a, 32'h0000_0000, q);
    endtask

    // Two counter reads exactly 64 cycles apart, so every rate divides evenly
    task automatic count_diff(output logic [31:0] d);
        logic [31:0] a;
        logic [31:0] b;
        t0 = cyc;
        rd(8'h0C, a);
        repeat (64 - (cyc - t0)) @(posedge clk);
        rd(8'h0C, b);
        d = b - a;
    endtask

    // One pin C edge; a capture both loads the register and clears the count
    task automatic cap_step(input logic lvl, input logic e);
        wr(8'h18, 32'h0000_1234);
        wr(8'h0C, 32'h0000_8000);
        ext_lvl[2] <= lvl;
        repeat (8) @(posedge clk);
        rd(8'h18, v0);
        check_bit("capture", e, v0 !== 32'h0000_1234);
        rd(8'h0C, v1);
        check_bit("capture clear", e, v1 < 32'h0000_0100);
    endtask

    // ----------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------
    initial begin
        reset   = 1'b1;
        hsel    = 1'b0;
        hwrite  = 1'b0;
        haddr   = 8'h00;
        htrans  = 2'b00;
        hwdata  = 32'h0000_0000;
        ext_lvl = 8'h00;
        cyc     = 0;
        repeat (12) @(posedge clk);
        reset <= 1'b0;
        check_val("pin drives", 32'h0000_0000, {24'h00_0000, pin_oe});
        // Reset values of both channels
        for (int c = 0; c < 2; c++) begin
            rd(8'(c * 64), v0);
            check_val("clock clear ctrl", 32'h0000_0000, v0);
            rd(8'(c * 64 + 4), v0);
            check_val("io ctrl a b", 32'h0000_0088, v0);
            rd(8'(c * 64 + 8), v0);
            check_val("io ctrl c d", 32'h0000_0088, v0);
        end
        // Table of ordinary register accesses
        foreach (rows[i]) begin
            if (rows[i].wr) begin
                wr(rows[i].a, rows[i].d);
            end
            rd(rows[i].a, v0);
            check_val("register", rows[i].e, v0);
        end
        // Internal rates
        for (int p = 0; p < 4; p++) begin
            wr(8'h00, 32'(p));
            count_diff(v0);
            check_val("internal rate", 32'(64 >> p), v0);
        end
        // External clock on pin 0, each edge choice
        for (int e = 0; e < 3; e++) begin
            wr(8'h00, 32'((e << 3) | 4));
            rd(8'h0C, v0);
            repeat (5) begin
                ext_lvl[0] <= 1'b1;
                repeat (8) @(posedge clk);
                ext_lvl[0] <= 1'b0;
                repeat (8) @(posedge clk);
            end
            rd(8'h0C, v1);
            check_val("external count", (e == 2) ? 32'd10 : 32'd5, v1 - v0);
        end
        // Clear sources: target register at 20, the others at 40
        for (int g = 0; g < 4; g++) begin
            wr(8'(16 + 4 * g), 32'd40);
        end
        for (int i = 0; i < 6; i++) begin
            if (i < 4) wr(8'(16 + 4 * i), 32'd20);
            wr(8'h00, 32'(clr_code[i] << 5));
            wr(8'h0C, 32'h0000_0000);
            repeat (100) @(posedge clk);
            rd(8'h0C, v0);
            check_bit("clear source", i < 4, v0 <= 32'd20);
            if (i < 4) wr(8'(16 + 4 * i), 32'd40);
        end
        // Channel 1 follows channel 0's clear only with sync enabled
        wr(8'h10, 32'd20);
        wr(8'h00, 32'h0000_0020);
        // Counter is far above 20 here; restart it so A can match
        wr(8'h0C, 32'h0000_0000);
        for (int s = 0; s < 2; s++) begin
            for (int c = 3; c < 8; c += 4) begin
                wr(8'h80, 32'(s));
                wr(8'h40, 32'(c << 5));
                wr(8'h4C, 32'h0000_8000);
                repeat (100) @(posedge clk);
                rd(8'h4C, v0);
                check_bit("sync clear", s[0], v0 <= 32'd20);
            end
        end
        wr(8'h80, 32'h0000_0000);
        // Compare actions on pin B, cleared by its own match
        // Lower B first so the counter never passes it while switching
        wr(8'h14, 32'd20);
        wr(8'h00, 32'h0000_0040);
        for (int k = 2; k >= 0; k--) begin
            wr(8'h04, 32'(k << 4));
            repeat (50) @(posedge clk);
            check_bit("compare drive", k != 0, pin_oe[1]);
            if (k != 0) check_bit("compare level", k == 2, pin_out[1]);
        end
        wr(8'h04, 32'h0000_0030);
        repeat (50) @(posedge clk);
        v0[0] = pin_out[1];
        repeat (21) @(posedge clk);
        check_bit("toggle", ~v0[0], pin_out[1]);
        // PWM modes 1 and 3 leave the pin undriven
        wr(8'h04, 32'h0000_0020);
        for (int m = 1; m < 4; m += 2) begin
            wr(8'h80, 32'(m << 4));
            repeat (20) @(posedge clk);
            check_bit("pwm ignores io", 1'b0, pin_oe[1]);
        end
        wr(8'h80, 32'h0000_0000);
        // Capture on pin C for each edge code, clearing on C
        wr(8'h04, 32'h0000_0000);
        wr(8'h00, 32'h0000_00A0);
        for (int c = 4; c < 7; c++) begin
            wr(8'h08, 32'(c));
            cap_step(1'b1, c != 5);
            cap_step(1'b0, c != 4);
            check_bit("capture no drive", 1'b0, pin_oe[2]);
        end
        check_bit("response", 1'b0, hresp);
        // Reset in mid-run returns registers and pins to idle
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        check_val("pin drives after reset", 32'h0000_0000, {24'h00_0000, pin_oe});
        rd(8'h00, v0);
        check_val("clock clear ctrl after reset", 32'h0000_0000, v0);
        stop_test();
    end
endmodule
